/* src/pag_pkg.sv */
// Package with command codes, reset values, timing and state types of the aux guard
package pag_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
	localparam logic [7:0] CMD_CAPTURE_CTRL  = 8'hF3;
	localparam logic [7:0] CMD_FACTORY_REV   = 8'hF4;
	localparam logic [7:0] CMD_AUX_OV_THR    = 8'hF5;
	localparam logic [7:0] CMD_AUX_UV_THR    = 8'hF6;
	localparam logic [7:0] CMD_AUX_READBACK  = 8'hF7;
	localparam logic [7:0] CMD_AUX_OV_RESP   = 8'hF8;
	localparam logic [7:0] CMD_AUX_UV_RESP   = 8'hF9;
	localparam logic [7:0] CMD_ACCESS_LEVEL  = 8'hFA;
	localparam logic [7:0] CMD_PRIVATE_PW    = 8'hFB;
	localparam logic [7:0] CMD_PUBLIC_PW     = 8'hFC;

	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [15:0] OV_THR_RESET     = 16'hC266;
	localparam logic [15:0] UV_THR_RESET     = 16'hB0CC;
	localparam logic [7:0]  RESP_RESET       = 8'hBF;
	localparam logic [7:0]  CAPTURE_RESET    = 8'h00;
	localparam logic [7:0]  CAPTURE_LOAD     = 8'h01;
	localparam logic [7:0]  CAPTURE_STORE    = 8'h02;
	localparam logic [7:0]  CAPTURE_ERASE    = 8'h03;
	localparam logic [1:0]  LEVEL_RESET      = 2'd1;
	localparam logic [1:0]  LEVEL_PUBLIC_OK  = 2'd1;
	localparam logic [1:0]  LEVEL_PUBLIC_BAD = 2'd0;
	localparam logic [1:0]  LEVEL_USER       = 2'd2;
	localparam logic [1:0]  LEVEL_FACTORY    = 2'd3;

	// ----------------------------------------------------------------
	// Response field layout
	// ----------------------------------------------------------------
	localparam int          RESP_MODE_HI     = 7;
	localparam int          RESP_MODE_LO     = 6;
	localparam int          RESP_RETRY_HI    = 5;
	localparam int          RESP_RETRY_LO    = 3;
	localparam int          RESP_DELAY_HI    = 2;
	localparam int          RESP_DELAY_LO    = 0;
	localparam logic [1:0]  MODE_LATCH_OFF   = 2'b10;
	localparam logic [1:0]  MODE_WHILE_FAULT = 2'b11;
	localparam logic [2:0]  RETRY_FOREVER    = 3'b111;

	// ----------------------------------------------------------------
	// Linear-11 layout and timing
	// ----------------------------------------------------------------
	localparam int          LIN_EXP_HI       = 15;
	localparam int          LIN_EXP_LO       = 11;
	localparam int          LIN_FIX_SHIFT    = 16;
	localparam int          CLK_PERIOD_NS    = 100;
	localparam int          MS_TICK_NS       = 1000000;
	localparam int          MS_TICK_CYCLES   = MS_TICK_NS / CLK_PERIOD_NS;
	localparam logic [8:0]  RETRY_STEP_MS    = 9'd35;

	typedef enum logic [2:0] {
		PAG_RUN     = 3'b000,
		PAG_WAIT_OK = 3'b001,
		PAG_DELAY   = 3'b011,
		PAG_HOLD    = 3'b010,
		PAG_LATCH   = 3'b110
	} pag_fault_e;

endpackage

/* src/pag_fault_channel.sv */
// One auxiliary fault channel: response decode, retry wait and delay timing
`timescale 1ns/1ps
module pag_fault_channel (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] resp_cfg,
	input  wire logic       fault_now,
	input  wire logic       recovered,
	input  wire logic       ms_tick,
	input  wire logic       clear_cmd,
	input  wire logic       off_cmd,
	output logic            inhibit_q,
	output logic            event_q
);
	import pag_pkg::*;

	pag_fault_e state_q, state_d;
	logic [8:0] cnt_q, cnt_d;
	logic       event_d;
	logic [1:0] mode;
	logic [8:0] target;

	// ----------------------------------------------------------------
	// Response decode
	// ----------------------------------------------------------------
	assign mode   = resp_cfg[RESP_MODE_HI:RESP_MODE_LO];
	assign target = 9'(({6'd0, resp_cfg[RESP_DELAY_HI:RESP_DELAY_LO]} + 9'd1)
		* RETRY_STEP_MS);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		event_d = 1'b0;
		case (state_q)
			PAG_RUN: begin
				cnt_d = 9'd0;
				if (fault_now && !off_cmd) begin
					if (mode == MODE_LATCH_OFF) begin
						event_d = 1'b1;
						if (resp_cfg[RESP_RETRY_HI:RESP_RETRY_LO] == RETRY_FOREVER) begin
							state_d = PAG_WAIT_OK;
						end else begin
							state_d = PAG_LATCH;
						end
					end else if (mode == MODE_WHILE_FAULT) begin
						event_d = 1'b1;
						state_d = PAG_HOLD;
					end
				end
			end
			PAG_HOLD: begin
				if (recovered || mode != MODE_WHILE_FAULT) begin
					state_d = PAG_RUN;
				end
			end
			PAG_WAIT_OK: begin
				if (off_cmd || mode != MODE_LATCH_OFF) begin
					state_d = PAG_RUN;
				end else if (recovered) begin
					state_d = PAG_DELAY;
				end
			end
			PAG_DELAY: begin
				if (off_cmd || mode != MODE_LATCH_OFF) begin
					state_d = PAG_RUN;
				end else if (ms_tick) begin
					cnt_d = 9'(cnt_q + 9'd1);
					if (9'(cnt_q + 9'd1) >= target) begin
						state_d = PAG_RUN;
					end
				end
			end
			PAG_LATCH: begin
				if (clear_cmd || mode != MODE_LATCH_OFF) begin
					state_d = PAG_RUN;
				end
			end
			default: begin
				state_d = PAG_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q   <= PAG_RUN;
			cnt_q     <= 9'd0;
			event_q   <= 1'b0;
			inhibit_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			event_q   <= event_d;
			inhibit_q <= (state_d != PAG_RUN);
		end
	end

endmodule

/* src/pag_guard.sv */
// Aux monitor, capture control, factory revert and write guard command logic
// Functional notes
// - Capture control: 01 load, 02 store, 03 erase
// - Factory revert reloads defaults, sets level one
// - Overvoltage warning at ninety percent of fault
// - Undervoltage warning at 110 percent of fault
// - Thresholds and readback use linear-11 format
// - Overvoltage threshold resets C266h, read/write
// - Undervoltage threshold resets B0CCh, read/write
// - Aux readback is read-only measured voltage
// - Response bits 7:6 select fault action
// - Acted fault pulls alert, sets sticky bit
// - Overvoltage mode 11 resumes below 95 percent
// - Undervoltage mode 11 resumes above 105 percent
// - Retry 000 keeps output off until cleared
// - Retry 111 restarts repeatedly until commanded off
// - Overvoltage retry waits below 95 percent
// - Undervoltage retry waits above 105 percent
// - Retry spacing is (delay+1) times 35 ms
// - Responses reset BFh; 00h disables the fault
// - Writes need permit; reads always allowed
// - Cleared permit bits need matching private password
// - Private password only ever raises level
// - Public password sets level 0 or 1
// - Access level readback resets to 01h
// - Factory-cleared command needs level three
// - User-cleared command needs level two
// - Wrong public password drops level to 0
// - Permit map bit n guards command n, except password commands FBh and FCh, which are always open
`timescale 1ns/1ps
module pag_guard #(
	parameter int MS_TICK_CYCLES = pag_pkg::MS_TICK_CYCLES
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         cmd_valid,
	input  wire logic         cmd_write,
	input  wire logic [7:0]   cmd_code,
	input  wire logic [31:0]  cmd_wdata,
	input  wire logic [255:0] factory_permit_map,
	input  wire logic [255:0] user_permit_map,
	input  wire logic [31:0]  factory_private_pw,
	input  wire logic [31:0]  user_private_pw,
	input  wire logic [31:0]  user_public_pw,
	input  wire logic         aux_sample_valid,
	input  wire logic [15:0]  aux_monitor_input,
	input  wire logic         output_commanded_off,
	input  wire logic         control_pin_off,
	output logic [15:0]       rd_data_q,
	output logic              rd_valid_q,
	output logic              wr_done_q,
	output logic              wr_refused_q,
	output logic              cmd_other_q,
	output logic              capture_load_q,
	output logic              capture_store_q,
	output logic              capture_erase_q,
	output logic              factory_reload_q,
	output logic              aux_output_inhibit_q,
	output logic              status_aux_ov_q,
	output logic              status_aux_uv_q,
	output logic              warn_aux_ov_q,
	output logic              warn_aux_uv_q,
	output logic              alert_line_o_q,
	output logic              alert_line_oe_q
);
	import pag_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	generate
		if (MS_TICK_CYCLES < 2) begin : g_bad_tick
			$error("MS_TICK_CYCLES must be at least 2");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Linear-11 to fixed point, scaled by 2^16
	// ----------------------------------------------------------------
	function automatic logic signed [55:0] lin_to_fix(input logic [15:0] v);
		logic signed [55:0] mant;
		logic [4:0]         sh;
		mant = 56'(signed'(v[LIN_EXP_LO-1:0]));
		sh   = 5'(v[LIN_EXP_HI:LIN_EXP_LO] + 5'(LIN_FIX_SHIFT));
		return mant <<< sh;
	endfunction

	// ----------------------------------------------------------------
	// Control pin synchroniser
	// ----------------------------------------------------------------
	logic pin_meta_q, pin_sync_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= control_pin_off;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Millisecond timebase
	// ----------------------------------------------------------------
	logic [31:0] pre_q, pre_d;
	logic        tick_q, tick_d;

	always_comb begin
		tick_d = 1'b0;
		pre_d  = pre_q + 32'd1;
		if (pre_q >= 32'(MS_TICK_CYCLES - 1)) begin
			pre_d  = 32'd0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pre_q  <= 32'd0;
			tick_q <= 1'b0;
		end else begin
			pre_q  <= pre_d;
			tick_q <= tick_d;
		end
	end

	// ----------------------------------------------------------------
	// Configuration and level registers
	// ----------------------------------------------------------------
	logic [15:0] ov_thr_q, ov_thr_d;
	logic [15:0] uv_thr_q, uv_thr_d;
	logic [15:0] aux_val_q, aux_val_d;
	logic [7:0]  ov_resp_q, ov_resp_d;
	logic [7:0]  uv_resp_q, uv_resp_d;
	logic [7:0]  capture_q, capture_d;
	logic [1:0]  level_q, level_d;
	logic [15:0] rd_data_d;
	logic        rd_valid_d, wr_done_d, wr_refused_d, cmd_other_d;
	logic        cap_load_d, cap_store_d, cap_erase_d, reload_d;
	logic        clear_faults;
	logic        protected_f, protected_u, always_open, permitted, known;
	logic        is_wr, is_rd;

	assign is_wr = cmd_valid && cmd_write;
	assign is_rd = cmd_valid && !cmd_write;

	// Permit decision for the addressed command
	always_comb begin
		protected_f = !factory_permit_map[cmd_code];
		protected_u = !user_permit_map[cmd_code];
		always_open = (cmd_code == CMD_PUBLIC_PW) || (cmd_code == CMD_PRIVATE_PW);
		if (always_open) begin
			permitted = 1'b1;
		end else if (protected_f) begin
			permitted = (level_q >= LEVEL_FACTORY);
		end else if (protected_u) begin
			permitted = (level_q >= LEVEL_USER);
		end else begin
			permitted = (level_q >= LEVEL_PUBLIC_OK);
		end
		case (cmd_code)
			CMD_CLEAR_FAULTS, CMD_CAPTURE_CTRL, CMD_FACTORY_REV, CMD_AUX_OV_THR,
			CMD_AUX_UV_THR, CMD_AUX_READBACK, CMD_AUX_OV_RESP, CMD_AUX_UV_RESP,
			CMD_ACCESS_LEVEL, CMD_PRIVATE_PW, CMD_PUBLIC_PW: begin
				known = 1'b1;
			end
			default: begin
				known = 1'b0;
			end
		endcase
	end

	always_comb begin
		ov_thr_d     = ov_thr_q;
		uv_thr_d     = uv_thr_q;
		aux_val_d    = aux_val_q;
		ov_resp_d    = ov_resp_q;
		uv_resp_d    = uv_resp_q;
		capture_d    = capture_q;
		level_d      = level_q;
		rd_data_d    = 16'h0000;
		rd_valid_d   = 1'b0;
		wr_done_d    = 1'b0;
		wr_refused_d = 1'b0;
		cmd_other_d  = cmd_valid && !known;
		cap_load_d   = 1'b0;
		cap_store_d  = 1'b0;
		cap_erase_d  = 1'b0;
		reload_d     = 1'b0;
		clear_faults = 1'b0;
		if (aux_sample_valid) begin
			aux_val_d = aux_monitor_input;
		end
		if (is_rd && known) begin
			rd_valid_d = 1'b1;
			case (cmd_code)
				CMD_AUX_OV_THR:   rd_data_d = ov_thr_q;
				CMD_AUX_UV_THR:   rd_data_d = uv_thr_q;
				CMD_AUX_READBACK: rd_data_d = aux_val_q;
				CMD_AUX_OV_RESP:  rd_data_d = {8'h00, ov_resp_q};
				CMD_AUX_UV_RESP:  rd_data_d = {8'h00, uv_resp_q};
				CMD_CAPTURE_CTRL: rd_data_d = {8'h00, capture_q};
				CMD_ACCESS_LEVEL: rd_data_d = {14'h0000, level_q};
				default:          rd_data_d = 16'h0000;
			endcase
		end
		if (is_wr && known) begin
			if (!permitted || cmd_code == CMD_AUX_READBACK || cmd_code == CMD_ACCESS_LEVEL) begin
				wr_refused_d = 1'b1;
			end else begin
				wr_done_d = 1'b1;
				case (cmd_code)
					CMD_CLEAR_FAULTS: clear_faults = 1'b1;
					CMD_AUX_OV_THR:   ov_thr_d = cmd_wdata[15:0];
					CMD_AUX_UV_THR:   uv_thr_d = cmd_wdata[15:0];
					CMD_AUX_OV_RESP:  ov_resp_d = cmd_wdata[7:0];
					CMD_AUX_UV_RESP:  uv_resp_d = cmd_wdata[7:0];
					CMD_CAPTURE_CTRL: begin
						if (cmd_wdata[7:0] == CAPTURE_LOAD) begin
							capture_d  = cmd_wdata[7:0];
							cap_load_d = 1'b1;
						end else if (cmd_wdata[7:0] == CAPTURE_STORE) begin
							capture_d   = cmd_wdata[7:0];
							cap_store_d = 1'b1;
						end else if (cmd_wdata[7:0] == CAPTURE_ERASE) begin
							capture_d   = cmd_wdata[7:0];
							cap_erase_d = 1'b1;
						end
					end
					CMD_FACTORY_REV: begin
						reload_d  = 1'b1;
						ov_thr_d  = OV_THR_RESET;
						uv_thr_d  = UV_THR_RESET;
						ov_resp_d = RESP_RESET;
						uv_resp_d = RESP_RESET;
						capture_d = CAPTURE_RESET;
						level_d   = LEVEL_PUBLIC_OK;
					end
					CMD_PRIVATE_PW: begin
						if (cmd_wdata == factory_private_pw) begin
							level_d = LEVEL_FACTORY;
						end else if (cmd_wdata == user_private_pw && level_q < LEVEL_USER) begin
							level_d = LEVEL_USER;
						end
					end
					CMD_PUBLIC_PW: begin
						if (cmd_wdata == user_public_pw) begin
							level_d = LEVEL_PUBLIC_OK;
						end else begin
							level_d = LEVEL_PUBLIC_BAD;
						end
					end
					default: wr_done_d = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ov_thr_q         <= OV_THR_RESET;
			uv_thr_q         <= UV_THR_RESET;
			aux_val_q        <= 16'h0000;
			ov_resp_q        <= RESP_RESET;
			uv_resp_q        <= RESP_RESET;
			capture_q        <= CAPTURE_RESET;
			level_q          <= LEVEL_RESET;
			rd_data_q        <= 16'h0000;
			rd_valid_q       <= 1'b0;
			wr_done_q        <= 1'b0;
			wr_refused_q     <= 1'b0;
			cmd_other_q      <= 1'b0;
			capture_load_q   <= 1'b0;
			capture_store_q  <= 1'b0;
			capture_erase_q  <= 1'b0;
			factory_reload_q <= 1'b0;
		end else begin
			ov_thr_q         <= ov_thr_d;
			uv_thr_q         <= uv_thr_d;
			aux_val_q        <= aux_val_d;
			ov_resp_q        <= ov_resp_d;
			uv_resp_q        <= uv_resp_d;
			capture_q        <= capture_d;
			level_q          <= level_d;
			rd_data_q        <= rd_data_d;
			rd_valid_q       <= rd_valid_d;
			wr_done_q        <= wr_done_d;
			wr_refused_q     <= wr_refused_d;
			cmd_other_q      <= cmd_other_d;
			capture_load_q   <= cap_load_d;
			capture_store_q  <= cap_store_d;
			capture_erase_q  <= cap_erase_d;
			factory_reload_q <= reload_d;
		end
	end

	// ----------------------------------------------------------------
	// Threshold comparison
	// ----------------------------------------------------------------
	logic signed [55:0] v_fix, ov_fix, uv_fix;
	logic               ov_fault, uv_fault, ov_ok, uv_ok, ov_warn, uv_warn;

	always_comb begin
		v_fix    = lin_to_fix(aux_val_q);
		ov_fix   = lin_to_fix(ov_thr_q);
		uv_fix   = lin_to_fix(uv_thr_q);
		ov_fault = v_fix >= ov_fix;
		uv_fault = v_fix <= uv_fix;
		ov_warn  = 56'(v_fix * 56'sd10) >= 56'(ov_fix * 56'sd9);
		uv_warn  = 56'(v_fix * 56'sd10) <= 56'(uv_fix * 56'sd11);
		ov_ok    = 56'(v_fix * 56'sd20) < 56'(ov_fix * 56'sd19);
		uv_ok    = 56'(v_fix * 56'sd20) > 56'(uv_fix * 56'sd21);
	end

	// ----------------------------------------------------------------
	// Fault channels
	// ----------------------------------------------------------------
	logic off_cmd, ov_inhibit, uv_inhibit, ov_event, uv_event;

	assign off_cmd = output_commanded_off || pin_sync_q;

	pag_fault_channel u_ov (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.resp_cfg  (ov_resp_q),
		.fault_now (ov_fault),
		.recovered (ov_ok),
		.ms_tick   (tick_q),
		.clear_cmd (clear_faults),
		.off_cmd   (off_cmd),
		.inhibit_q (ov_inhibit),
		.event_q   (ov_event)
	);

	pag_fault_channel u_uv (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.resp_cfg  (uv_resp_q),
		.fault_now (uv_fault),
		.recovered (uv_ok),
		.ms_tick   (tick_q),
		.clear_cmd (clear_faults),
		.off_cmd   (off_cmd),
		.inhibit_q (uv_inhibit),
		.event_q   (uv_event)
	);

	// ----------------------------------------------------------------
	// Status, warning and alert
	// ----------------------------------------------------------------
	logic st_ov_d, st_uv_d, alert_d;

	always_comb begin
		st_ov_d = status_aux_ov_q;
		st_uv_d = status_aux_uv_q;
		if (clear_faults) begin
			st_ov_d = 1'b0;
			st_uv_d = 1'b0;
		end
		if (ov_event) begin
			st_ov_d = 1'b1;
		end
		if (uv_event) begin
			st_uv_d = 1'b1;
		end
		alert_d = st_ov_d || st_uv_d;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			status_aux_ov_q      <= 1'b0;
			status_aux_uv_q      <= 1'b0;
			warn_aux_ov_q        <= 1'b0;
			warn_aux_uv_q        <= 1'b0;
			alert_line_o_q       <= 1'b0;
			alert_line_oe_q      <= 1'b0;
			aux_output_inhibit_q <= 1'b0;
		end else begin
			status_aux_ov_q      <= st_ov_d;
			status_aux_uv_q      <= st_uv_d;
			warn_aux_ov_q        <= ov_warn && (ov_resp_q != 8'h00);
			warn_aux_uv_q        <= uv_warn && (uv_resp_q != 8'h00);
			alert_line_o_q       <= 1'b0;
			alert_line_oe_q      <= alert_d;
			aux_output_inhibit_q <= ov_inhibit || uv_inhibit;
		end
	end

endmodule

/* testbench/pag_guard_assertions.sv */
// Concurrent checks on the aux guard command and fault ports
`timescale 1ns/1ps
module pag_guard_assertions import pag_pkg::*; (
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic [7:0]  cmd_code,
	input wire logic [31:0] cmd_wdata,
	input wire logic [15:0] rd_data_q,
	input wire logic        rd_valid_q,
	input wire logic        wr_done_q,
	input wire logic        wr_refused_q,
	input wire logic        cmd_other_q,
	input wire logic        capture_load_q,
	input wire logic        status_aux_ov_q,
	input wire logic        alert_line_o_q,
	input wire logic        alert_line_oe_q
);
	logic wr_v;
	logic clr;
	logic ans;
	assign wr_v = cmd_valid && cmd_write;
	assign clr = wr_v && cmd_code == CMD_CLEAR_FAULTS;
	assign ans = rd_valid_q | wr_done_q | wr_refused_q | cmd_other_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_one_answer:
		assert property (cmd_valid |=> $onehot({rd_valid_q, wr_done_q, wr_refused_q, cmd_other_q}))
		else $error("not one answer");
	chk_no_answer:
		assert property (!cmd_valid |=> !ans) else $error("answer without command");
	chk_ro_refused:
		assert property (wr_v && (cmd_code == CMD_AUX_READBACK || cmd_code == CMD_ACCESS_LEVEL)
			|=> wr_refused_q) else $error("read-only write taken");
	chk_read_open:
		assert property (cmd_valid && !cmd_write |=> rd_valid_q || cmd_other_q)
		else $error("read refused");
	chk_capture_load:
		assert property (wr_v && cmd_code == CMD_CAPTURE_CTRL && cmd_wdata[7:0] == CAPTURE_LOAD
			|=> capture_load_q == wr_done_q) else $error("load pulse wrong");
	chk_alert_level:
		assert property (alert_line_o_q == 1'b0) else $error("alert driven high");
	chk_status_alert:
		assert property ($rose(status_aux_ov_q) |-> alert_line_oe_q) else $error("no alert");
	chk_sticky_status:
		assert property ($fell(status_aux_ov_q) |-> $past(clr) || $past(clr, 2))
		else $error("status lost");
	chk_rdata_idle:
		assert property (!rd_valid_q |-> rd_data_q == 16'h0000) else $error("stray read data");
endmodule
bind pag_guard pag_guard_assertions u_chk (
	.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
	.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q),
	.rd_valid_q(rd_valid_q), .wr_done_q(wr_done_q), .wr_refused_q(wr_refused_q),
	.cmd_other_q(cmd_other_q), .capture_load_q(capture_load_q),
	.status_aux_ov_q(status_aux_ov_q), .alert_line_o_q(alert_line_o_q),
	.alert_line_oe_q(alert_line_oe_q)
);

/* testbench/pag_host.sv */
// Management host model issuing decoded commands
`timescale 1ns/1ps
module pag_host (
	input  wire logic        mclk,
	input  wire logic [15:0] rd_data_q,
	input  wire logic        rd_valid_q,
	input  wire logic        wr_done_q,
	input  wire logic        wr_refused_q,
	input  wire logic        cmd_other_q,
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [7:0]       cmd_code,
	output logic [31:0]      cmd_wdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 32'h0000_0000;
	end
	// One command; released code and data are inverted so stale values never pass
	task xfer(input logic w, input logic [7:0] c, input logic [31:0] d,
		output logic [3:0] a, output logic [15:0] r);
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = c;
		cmd_wdata = d;
		@(negedge mclk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~d;
		a = {rd_valid_q, wr_done_q, wr_refused_q, cmd_other_q};
		r = rd_data_q;
	endtask
endmodule

/* testbench/pag_guard_tb.sv */
// Self-checking bench for the aux guard
`timescale 1ns/1ps
module pag_guard_tb;
	import pag_pkg::*;
	localparam logic [31:0] PUB = 32'h1234_5678;
	localparam logic [31:0] UPW = 32'hA5A5_0002;
	localparam logic [31:0] FPW = 32'h5A5A_0003;
	logic         mclk = 1'b0;
	logic         sys_rst = 1'b1;
	logic [255:0] fmap = '1;
	logic [255:0] umap = '1;
	logic         smp = 1'b0;
	logic [15:0]  aux = 16'h0000;
	logic         off = 1'b0;
	logic         pin_off = 1'b0;
	logic         cv, cw, rv, wd, wrf, oth, inh, sov, wov, aoe, frl, suv, wuv;
	logic [7:0]   cc;
	logic [31:0]  cd;
	logic [15:0]  rdat, d;
	logic [3:0]   a;
	logic [2:0]   cap;
	int           err_count = 0;
	int           n_tests = 0;
	always #50 mclk = ~mclk;
	pag_guard #(.MS_TICK_CYCLES(4)) DUT (
		.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cv), .cmd_write(cw), .cmd_code(cc),
		.cmd_wdata(cd), .factory_permit_map(fmap), .user_permit_map(umap),
		.factory_private_pw(FPW), .user_private_pw(UPW), .user_public_pw(PUB),
		.aux_sample_valid(smp), .aux_monitor_input(aux), .output_commanded_off(off),
		.control_pin_off(pin_off), .rd_data_q(rdat), .rd_valid_q(rv), .wr_done_q(wd),
		.wr_refused_q(wrf), .cmd_other_q(oth), .capture_load_q(cap[2]),
		.capture_store_q(cap[1]), .capture_erase_q(cap[0]), .factory_reload_q(frl),
		.aux_output_inhibit_q(inh), .status_aux_ov_q(sov), .status_aux_uv_q(suv),
		.warn_aux_ov_q(wov), .warn_aux_uv_q(wuv), .alert_line_o_q(), .alert_line_oe_q(aoe)
	);
	pag_host H (.mclk(mclk), .rd_data_q(rdat), .rd_valid_q(rv), .wr_done_q(wd),
		.wr_refused_q(wrf), .cmd_other_q(oth), .cmd_valid(cv), .cmd_write(cw),
		.cmd_code(cc), .cmd_wdata(cd));
	task stop_test();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rd(input logic [7:0] c, input logic [15:0] e);
		H.xfer(1'b0, c, 32'h0000_0000, a, d);
		chk({12'h000, a}, 16'h0008);
		chk(d, e);
	endtask
	task wr(input logic [7:0] c, input logic [31:0] v, input logic [3:0] e);
		H.xfer(1'b1, c, v, a, d);
		chk({12'h000, a}, {12'h000, e});
	endtask
	task samp(input logic [15:0] v);
		@(negedge mclk);
		aux = v;
		smp = 1'b1;
		@(negedge mclk);
		smp = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
	task ih(input logic e);
		chk({15'h0000, inh}, {15'h0000, e});
	endtask
	initial begin
		repeat (5000) @(posedge mclk);
		err_count++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		rd(CMD_AUX_OV_THR, 16'hC266);
		rd(CMD_AUX_UV_THR, 16'hB0CC);
		rd(CMD_AUX_OV_RESP, 16'h00BF);
		rd(CMD_AUX_UV_RESP, 16'h00BF);
		rd(CMD_ACCESS_LEVEL, 16'h0001);
		rd(CMD_AUX_READBACK, 16'h0000);
		chk({12'h000, inh, suv, wuv, aoe}, 16'h000F);
		wr(CMD_AUX_READBACK, 32'h0000_0000, 4'h2);
		wr(CMD_ACCESS_LEVEL, 32'h0000_0003, 4'h2);
		wr(8'h10, 32'h0000_0000, 4'h1);
		off = 1'b1;
		for (int i = 1; i < 4; i++) begin
			wr(CMD_CAPTURE_CTRL, 32'(i), 4'h4);
			chk({13'h0000, cap}, 16'h0008 >> i);
			rd(CMD_CAPTURE_CTRL, 16'(i));
		end
		off = 1'b0;
		wr(CMD_PUBLIC_PW, 32'h0000_0000, 4'h4);
		rd(CMD_ACCESS_LEVEL, 16'h0000);
		wr(CMD_AUX_OV_RESP, 32'h0000_0080, 4'h2);
		wr(CMD_PUBLIC_PW, PUB, 4'h4);
		rd(CMD_ACCESS_LEVEL, 16'h0001);
		fmap[CMD_AUX_OV_RESP] = 1'b0;
		wr(CMD_AUX_OV_RESP, 32'h0000_0080, 4'h2);
		wr(CMD_PRIVATE_PW, UPW, 4'h4);
		rd(CMD_ACCESS_LEVEL, 16'h0002);
		wr(CMD_AUX_OV_RESP, 32'h0000_0080, 4'h2);
		wr(CMD_PRIVATE_PW, FPW, 4'h4);
		wr(CMD_AUX_OV_RESP, 32'h0000_0080, 4'h4);
		wr(CMD_PRIVATE_PW, UPW, 4'h4);
		rd(CMD_ACCESS_LEVEL, 16'h0003);
		wr(CMD_FACTORY_REV, 32'h0000_0000, 4'h4);
		chk({15'h0000, frl}, 16'h0001);
		rd(CMD_ACCESS_LEVEL, 16'h0001);
		rd(CMD_AUX_OV_RESP, 16'h00BF);
		fmap = '1;
		umap[CMD_AUX_UV_RESP] = 1'b0;
		wr(CMD_AUX_UV_RESP, 32'h0000_0080, 4'h2);
		umap = '1;
		wr(CMD_AUX_UV_RESP, 32'h0000_0000, 4'h4);
		wr(CMD_AUX_OV_RESP, 32'h0000_0080, 4'h4);
		wr(CMD_CLEAR_FAULTS, 32'h0000_0000, 4'h4);
		chk({13'h0000, inh, aoe, wuv}, 16'h0000);
		samp(16'hC300);
		chk({13'h0000, inh, sov, aoe}, 16'h0007);
		samp(16'hC100);
		ih(1'b1);
		wr(CMD_CLEAR_FAULTS, 32'h0000_0000, 4'h4);
		chk({15'h0000, sov}, 16'h0000);
		samp(16'hC240);
		chk({14'h0000, wov, sov}, 16'h0002);
		wr(CMD_AUX_OV_RESP, 32'h0000_00B8, 4'h4);
		samp(16'hC300);
		ih(1'b1);
		samp(16'hC100);
		repeat (120) @(negedge mclk);
		ih(1'b1);
		repeat (40) @(negedge mclk);
		ih(1'b0);
		samp(16'hC300);
		ih(1'b1);
		pin_off = 1'b1;
		samp(16'hC300);
		ih(1'b0);
		pin_off = 1'b0;
		wr(CMD_CLEAR_FAULTS, 32'h0000_0000, 4'h4);
		wr(CMD_AUX_OV_RESP, 32'h0000_00C0, 4'h4);
		samp(16'hC300);
		ih(1'b1);
		samp(16'hC250);
		ih(1'b1);
		samp(16'hC100);
		ih(1'b0);
		stop_test();
	end
endmodule
